// ==== common/cof_pkg.sv ====
// Package of constants and carrier types for the output clamp and filter
package cof_pkg;

  // ----------------------------------------------------------------------
  // Widths and arithmetic
  // ----------------------------------------------------------------------
  localparam int unsigned CODE_W = 16;
  localparam int unsigned FRAC_BITS = 14;
  localparam logic [15:0] UNITY_COEF = 16'h4000;
  localparam logic [15:0] FILTER_OFF_A0 = 16'h0000;
  localparam logic [15:0] ZERO_CODE = 16'h0000;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [15:0] DAC_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Signal-chain mask bit positions
  // ----------------------------------------------------------------------
  localparam int unsigned MB_BRIDGE_INPUT_OVER_LIMIT = 0;
  localparam int unsigned MB_BRIDGE_INPUT_UNDER_LIMIT = 1;
  localparam int unsigned MB_TIN_OV = 2;
  localparam int unsigned MB_PAMP_OV = 4;
  localparam int unsigned MB_PAMP_UV = 5;
  localparam int unsigned MB_TAMP_OV = 6;
  localparam int unsigned MB_TAMP_UV = 7;
  localparam int unsigned SUPPLY_RAILS = 5;

  // ----------------------------------------------------------------------
  // Fault reaction timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned FAULT_MIN_MS = 8;
  localparam int unsigned FAULT_MIN_CYC = FAULT_MIN_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] a0;
    logic [15:0] a1;
    logic [15:0] a2;
    logic [15:0] b0;
    logic [15:0] b1;
    logic [15:0] b2;
  } cof_iir_coef_type;

  typedef struct packed {
    logic [15:0] low_clamp;
    logic [15:0] high_clamp;
    logic [15:0] normal_low;
    logic [15:0] normal_high;
  } cof_limits_type;

  typedef struct packed {
    logic [1:0] pulldown_select;
    logic [2:0] open_detect_threshold;
    logic pressure_sense_resistor_off;
    logic temp_sense_resistor_off;
  } cof_frontend_cfg_type;

  typedef struct packed {
    logic [SUPPLY_RAILS-1:0] rail_over;
    logic [SUPPLY_RAILS-1:0] rail_under;
    logic [1:0] bridge_over;
    logic [1:0] bridge_under;
    logic [1:0] temp_pin_over;
    logic pressure_amp_over_limit;
    logic pressure_amp_under_limit;
    logic temp_amp_over_limit;
    logic temp_amp_under_limit;
  } cof_monitor_type;

endpackage : cof_pkg

// ==== hw/cof_fifo.sv ====
// Small valid/ready FIFO placed in the sample path
`timescale 1ns/1ps
`default_nettype none
module cof_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  // Storage writes
  always_ff @(posedge clk) begin
    if (clk_en && push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule : cof_fifo
`default_nettype wire

// ==== hw/cof_top.sv ====
// Output mapping, clamp, IIR filter and fault forcing ahead of the DAC
`timescale 1ns/1ps
`default_nettype none
module cof_top #(
  parameter int unsigned FAULT_CYC = cof_pkg::FAULT_MIN_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Pressure sample stream from the decimator
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [15:0] pressure_sample,
  // Mapping and filter settings from nonvolatile memory
  input wire logic [15:0] bypass_offset,
  input wire logic [15:0] bypass_gain,
  input wire cof_pkg::cof_limits_type limits,
  input wire cof_pkg::cof_iir_coef_type iir_coef,
  input wire logic [7:0] fault_code_low,
  input wire logic [7:0] fault_code_high,
  input wire logic nvm_crc_good,
  input wire logic nvm_corrupt,
  // Configuration bits
  input wire logic diagnostics_master_on,
  input wire cof_pkg::cof_frontend_cfg_type frontend_check_config,
  input wire logic mask_write,
  input wire logic [7:0] mask_wdata,
  // Raw fault monitors from analog comparators
  input wire cof_pkg::cof_monitor_type monitors,
  input wire logic exec_timing_error,
  input wire logic logic_checksum_error,
  // DAC side
  output logic [15:0] dac_code,
  output logic dac_valid,
  output logic dac_enable,
  // Front-end control and status
  output logic [7:0] signal_chain_fault_mask,
  output logic [1:0] pulldown_select,
  output logic [2:0] open_detect_threshold,
  output logic pressure_sense_resistor_off,
  output logic temp_sense_resistor_off,
  output logic [7:0] chain_fault_status,
  output logic supply_fault_status
);
  localparam int unsigned CW = $clog2(FAULT_CYC + 1);

  // --------------------------------------------------------------------
  // Input synchronisers for pin-level monitors
  // --------------------------------------------------------------------
  localparam int unsigned MON_W = $bits(cof_pkg::cof_monitor_type) + 2;
  logic [MON_W-1:0] mon_raw;
  logic [MON_W-1:0] mon_s1_ff;
  logic [MON_W-1:0] mon_s2_ff;
  cof_pkg::cof_monitor_type mon;
  logic timing_err;
  logic checksum_err;

  assign mon_raw = {monitors, exec_timing_error, logic_checksum_error};

  // Two flops per monitor bit
  genvar gi;
  generate
    for (gi = 0; gi < MON_W; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          mon_s1_ff[gi] <= 1'b0;
          mon_s2_ff[gi] <= 1'b0;
        end else if (clk_en) begin
          mon_s1_ff[gi] <= mon_raw[gi];
          mon_s2_ff[gi] <= mon_s1_ff[gi];
        end
      end
    end
  endgenerate

  assign mon = mon_s2_ff[MON_W-1:2];
  assign timing_err = mon_s2_ff[1];
  assign checksum_err = mon_s2_ff[0];

  // --------------------------------------------------------------------
  // Mask register and front-end configuration
  // --------------------------------------------------------------------
  logic [7:0] mask_ff;

  // Software-writable mask; bit 3 has no fault behind it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_ff <= cof_pkg::MASK_RESET;
    end else if (clk_en && mask_write) begin
      mask_ff <= mask_wdata;
    end
  end

  // Registered front-end settings to the analog comparators
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pulldown_select <= '0;
      open_detect_threshold <= '0;
      pressure_sense_resistor_off <= 1'b0;
      temp_sense_resistor_off <= 1'b0;
      signal_chain_fault_mask <= cof_pkg::MASK_RESET;
    end else if (clk_en) begin
      pulldown_select <= frontend_check_config.pulldown_select;
      open_detect_threshold <=
        frontend_check_config.open_detect_threshold;
      pressure_sense_resistor_off <=
        frontend_check_config.pressure_sense_resistor_off;
      temp_sense_resistor_off <=
        frontend_check_config.temp_sense_resistor_off;
      signal_chain_fault_mask <= mask_ff;
    end
  end

  // --------------------------------------------------------------------
  // Fault detection
  // --------------------------------------------------------------------
  logic [7:0] chain_raw;
  logic [7:0] chain_en;
  logic supply_raw;
  logic fault_now;

  // Chain faults by mask position; either bridge pin trips a bit
  always_comb begin
    chain_raw = '0;
    chain_raw[cof_pkg::MB_BRIDGE_INPUT_OVER_LIMIT] = |mon.bridge_over;
    chain_raw[cof_pkg::MB_BRIDGE_INPUT_UNDER_LIMIT] = |mon.bridge_under;
    chain_raw[cof_pkg::MB_TIN_OV] = |mon.temp_pin_over;
    chain_raw[cof_pkg::MB_PAMP_OV] = mon.pressure_amp_over_limit;
    chain_raw[cof_pkg::MB_PAMP_UV] = mon.pressure_amp_under_limit;
    chain_raw[cof_pkg::MB_TAMP_OV] = mon.temp_amp_over_limit;
    chain_raw[cof_pkg::MB_TAMP_UV] = mon.temp_amp_under_limit;
  end

  assign chain_en = chain_raw & mask_ff;
  assign supply_raw = (|mon.rail_over) | (|mon.rail_under);
  assign fault_now = supply_raw | (|chain_en);

  // Persistence counter: a fault must hold 8 ms before it acts
  logic [CW-1:0] persist_ff;
  logic run_fault_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      persist_ff <= '0;
      run_fault_ff <= 1'b0;
    end else if (clk_en) begin
      if (!fault_now) begin
        persist_ff <= '0;
        run_fault_ff <= 1'b0;
      end else if (persist_ff != CW'(FAULT_CYC)) begin
        persist_ff <= persist_ff + 1'b1;
      end else begin
        run_fault_ff <= 1'b1;
      end
    end
  end

  // Status outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chain_fault_status <= '0;
      supply_fault_status <= 1'b0;
    end else if (clk_en) begin
      chain_fault_status <= chain_en;
      supply_fault_status <= supply_raw;
    end
  end

  logic hard_err;
  logic nvm_bad;
  assign hard_err = diagnostics_master_on &&
                    (timing_err || checksum_err);
  assign nvm_bad = diagnostics_master_on &&
                   (nvm_corrupt || !nvm_crc_good);

  // --------------------------------------------------------------------
  // Sample FIFO
  // --------------------------------------------------------------------
  logic fifo_valid;
  logic fifo_ready;
  logic [15:0] fifo_data;
  logic in_ready_w;

  cof_fifo #(
    .WIDTH(cof_pkg::CODE_W),
    .DEPTH(4)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst || (clk_en && hard_err)),
    .clk_en(clk_en),
    .in_valid(sample_valid && sample_ready),
    .in_ready(in_ready_w),
    .in_data(pressure_sample),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );
  // Registered ready, low for a cycle after each take so it never overruns
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sample_ready <= 1'b0;
    end else if (clk_en) begin
      sample_ready <= in_ready_w && !hard_err &&
                      !(sample_valid && sample_ready);
    end
  end

  // --------------------------------------------------------------------
  // Pipeline: map, clamp, filter
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_MAP, ST_CLAMP, ST_FILT} cof_st_type;
  cof_st_type state_ff;
  logic [15:0] mapped_ff;
  logic [15:0] clamped_ff;
  logic signed [15:0] w1_ff;
  logic signed [15:0] w2_ff;
  logic [15:0] filt_ff;

  assign fifo_ready = (state_ff == ST_IDLE) && !hard_err;

  // Sample products in 14-bit fixed point
  logic signed [33:0] gain_prod;
  logic signed [15:0] map_val;
  assign gain_prod = $signed(bypass_gain) * $signed({1'b0, fifo_data});
  assign map_val = 16'($signed(bypass_offset) +
                       16'(gain_prod >>> cof_pkg::FRAC_BITS));

  // IIR sums, coefficients as signed Q2.14
  logic signed [35:0] w_sum;
  logic signed [35:0] y_sum;
  logic signed [15:0] w_new;
  always_comb begin
    w_sum = 36'($signed(iir_coef.a0) * $signed({1'b0, clamped_ff}))
          + 36'($signed(iir_coef.a1) * w1_ff)
          + 36'($signed(iir_coef.a2) * w2_ff);
    w_new = 16'(w_sum >>> cof_pkg::FRAC_BITS);
    y_sum = 36'($signed(iir_coef.b0) * w_new)
          + 36'($signed(iir_coef.b1) * w1_ff)
          + 36'($signed(iir_coef.b2) * w2_ff);
  end

  // Sequencer; an internal hard error holds it in reset
  always_ff @(posedge clk) begin
    if (sys_rst || (clk_en && hard_err)) begin
      state_ff <= ST_IDLE;
      mapped_ff <= '0;
      clamped_ff <= '0;
      w1_ff <= '0;
      w2_ff <= '0;
      filt_ff <= '0;
    end else if (clk_en) begin
      case (state_ff)
        ST_IDLE: begin
          if (fifo_valid) begin
            mapped_ff <= map_val;
            state_ff <= ST_MAP;
          end
        end
        ST_MAP: begin
          if (mapped_ff > limits.normal_high) begin
            clamped_ff <= limits.high_clamp;
          end else if (mapped_ff < limits.normal_low) begin
            clamped_ff <= limits.low_clamp;
          end else begin
            clamped_ff <= mapped_ff;
          end
          state_ff <= ST_CLAMP;
        end
        ST_CLAMP: begin
          if (iir_coef.a0 == cof_pkg::FILTER_OFF_A0) begin
            filt_ff <= clamped_ff;
          end else begin
            filt_ff <= 16'(y_sum >>> cof_pkg::FRAC_BITS);
            w1_ff <= w_new;
            w2_ff <= w1_ff;
          end
          state_ff <= ST_FILT;
        end
        ST_FILT: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // DAC output with fault overrides
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dac_code <= cof_pkg::DAC_RESET;
      dac_valid <= 1'b0;
      dac_enable <= 1'b0;
    end else if (clk_en) begin
      dac_valid <= (state_ff == ST_FILT) && !hard_err;
      dac_enable <= !hard_err;
      if (hard_err) begin
        dac_code <= cof_pkg::ZERO_CODE;
      end else if (nvm_bad) begin
        dac_code <= cof_pkg::ZERO_CODE;
      end else if (diagnostics_master_on && run_fault_ff) begin
        dac_code <= {fault_code_high, fault_code_low};
      end else begin
        dac_code <= filt_ff;
      end
    end
  end
endmodule : cof_top
`default_nettype wire

// ==== verification/cof_top_asserts.sv ====
// Port checker for the output clamp, filter and fault forcing block
`timescale 1ns/1ps
`default_nettype none
module cof_top_chk #(
  parameter int unsigned FAULT_CYC = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Inputs that cause forcing
  input wire logic clk_en,
  input wire logic diagnostics_master_on,
  input wire logic nvm_crc_good,
  input wire logic nvm_corrupt,
  input wire logic exec_timing_error,
  input wire logic logic_checksum_error,
  input wire logic mask_write,
  input wire logic [7:0] mask_wdata,
  input wire logic [7:0] fault_code_low,
  input wire logic [7:0] fault_code_high,
  // Outputs under watch
  input wire logic sample_ready,
  input wire logic [15:0] dac_code,
  input wire logic dac_valid,
  input wire logic dac_enable,
  input wire logic [7:0] signal_chain_fault_mask,
  input wire logic [7:0] chain_fault_status,
  input wire logic supply_fault_status
);
  localparam int FC = int'(FAULT_CYC);
  logic hard;
  logic nvm_bad;
  logic clean;
  logic any_fault;
  logic [15:0] fcode;
  int run_ff;

  // Conditions that the forcing logic reacts to
  assign hard = clk_en && diagnostics_master_on &&
    (exec_timing_error || logic_checksum_error);
  assign nvm_bad = clk_en && diagnostics_master_on &&
    (!nvm_crc_good || nvm_corrupt);
  assign clean = diagnostics_master_on && nvm_crc_good && !nvm_corrupt &&
    !exec_timing_error && !logic_checksum_error;
  assign any_fault = (chain_fault_status != 8'h00) || supply_fault_status;
  assign fcode = {fault_code_high, fault_code_low};

  // Cycles a reported fault has stood; saturates well past the deadline
  always_ff @(posedge clk) begin
    if (sys_rst || !any_fault) begin
      run_ff <= 0;
    end else if (run_ff < FC + 16) begin
      run_ff <= run_ff + 1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_HARD_OFF: assert property (
    hard [*5] |-> !dac_enable && dac_code == 16'h0000)
    else $error("dac not shut down on hard error");
  AST_HARD_READY: assert property (hard [*5] |-> !sample_ready)
    else $error("samples accepted during hard error");
  AST_NVM_ZERO: assert property (nvm_bad [*3] |-> dac_code == 16'h0000)
    else $error("dac code not zero with bad memory");
  AST_FAULT_EARLY: assert property (
    run_ff > 0 && run_ff < FC - 6 |-> dac_code != fcode)
    else $error("fault code forced too early");
  AST_FAULT_ACT: assert property (
    run_ff == FC + 8 && clean |-> dac_code == fcode)
    else $error("fault code not forced in time");
  AST_MASK_WRITE: assert property (
    mask_write |-> ##2 signal_chain_fault_mask == $past(mask_wdata, 2))
    else $error("mask write lost");
  AST_MASK_GATE: assert property (
    $stable(signal_chain_fault_mask) |->
    (chain_fault_status & ~signal_chain_fault_mask) == 8'h00)
    else $error("masked fault reported");
  AST_BIT3_IDLE: assert property (chain_fault_status[3] == 1'b0)
    else $error("unused status bit set");
  AST_VALID_PULSE: assert property (
    dac_valid |=> !dac_valid ##1 !dac_valid)
    else $error("dac valid too close");

  // Main scenarios reached
  cover property (dac_valid);
  cover property (dac_code == fcode && run_ff > 0);
  cover property (!dac_enable);
  cover property (mask_write);
endmodule : cof_top_chk

bind cof_top cof_top_chk #(.FAULT_CYC(FAULT_CYC)) cof_top_chk_inst (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .diagnostics_master_on(diagnostics_master_on),
  .nvm_crc_good(nvm_crc_good), .nvm_corrupt(nvm_corrupt),
  .exec_timing_error(exec_timing_error),
  .logic_checksum_error(logic_checksum_error),
  .mask_write(mask_write), .mask_wdata(mask_wdata),
  .fault_code_low(fault_code_low), .fault_code_high(fault_code_high),
  .sample_ready(sample_ready), .dac_code(dac_code),
  .dac_valid(dac_valid), .dac_enable(dac_enable),
  .signal_chain_fault_mask(signal_chain_fault_mask),
  .chain_fault_status(chain_fault_status),
  .supply_fault_status(supply_fault_status)
);
`default_nettype wire

// ==== verification/cof_partner.sv ====
// Model of the sample decimator feeding the block and the DAC behind it
`timescale 1ns/1ps
`default_nettype none
module cof_partner (
  // Clock
  input wire logic clk,
  // Sample stream towards the block
  output logic sample_valid,
  input wire logic sample_ready,
  output logic [15:0] pressure_sample,
  // DAC side
  input wire logic [15:0] dac_code,
  input wire logic dac_valid
);
  logic [15:0] got[$];

  // Idle stream with a junk word on the data lines
  initial begin
    sample_valid = 1'b0;
    pressure_sample = 16'hA5A5;
  end

  // Offer one word, hold it until an edge sees ready, then let go
  task automatic send(input logic [15:0] v);
    @(negedge clk);
    sample_valid = 1'b1;
    pressure_sample = v;
    do @(posedge clk); while (sample_ready !== 1'b1);
    @(negedge clk);
    sample_valid = 1'b0;
    pressure_sample = ~v;
  endtask : send

  // Latch every finished code, as the converter would
  always @(posedge clk) begin
    if (dac_valid) begin
      got.push_back(dac_code);
    end
  end
endmodule : cof_partner
`default_nettype wire

// ==== verification/test_compensation_output_clamp_filter_diag.sv ====
// Self-checking bench for the output clamp, filter and fault forcing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin \
  mismatches++; $display("unexpected %s exp %h got %h", what, exp, got); \
  end end
module test_compensation_output_clamp_filter_diag;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sample_valid, sample_ready, dac_valid, dac_enable;
  logic p_off, t_off, sup_st;
  logic nvm_crc_good = 1'b1;
  logic nvm_corrupt = 1'b0;
  logic diag_on = 1'b1;
  logic mask_write = 1'b0;
  logic exec_err = 1'b0;
  logic sum_err = 1'b0;
  logic [15:0] sample, dac_code;
  logic [15:0] offset = 16'h0000;
  logic [15:0] gain = 16'h4000;
  logic [7:0] mask_wdata = 8'h00;
  logic [7:0] mask_q, chain_st;
  logic [1:0] pd_q;
  logic [2:0] thr_q;
  cof_pkg::cof_limits_type limits = 64'h0000_FFFF_0000_FFFF;
  cof_pkg::cof_iir_coef_type coef = '0;
  cof_pkg::cof_frontend_cfg_type fcfg = '0;
  cof_pkg::cof_monitor_type mon = '0;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;

  // Block under test, short fault delay, fault code 0xBEEF
  cof_top #(.FAULT_CYC(20)) cof_top_inst (
    .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .pressure_sample(sample), .bypass_offset(offset), .bypass_gain(gain),
    .limits(limits), .iir_coef(coef), .fault_code_low(8'hEF),
    .fault_code_high(8'hBE), .nvm_crc_good(nvm_crc_good),
    .nvm_corrupt(nvm_corrupt), .diagnostics_master_on(diag_on),
    .frontend_check_config(fcfg), .mask_write(mask_write),
    .mask_wdata(mask_wdata), .monitors(mon),
    .exec_timing_error(exec_err), .logic_checksum_error(sum_err),
    .dac_code(dac_code), .dac_valid(dac_valid), .dac_enable(dac_enable),
    .signal_chain_fault_mask(mask_q), .pulldown_select(pd_q),
    .open_detect_threshold(thr_q), .pressure_sense_resistor_off(p_off),
    .temp_sense_resistor_off(t_off), .chain_fault_status(chain_st),
    .supply_fault_status(sup_st)
  );
  cof_partner cof_partner_inst (
    .clk(clk), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .pressure_sample(sample), .dac_code(dac_code), .dac_valid(dac_valid)
  );

  // Clock and hang guard
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Send one word and compare the code the DAC latched for it
  task automatic xfer(input logic [15:0] v, input logic [15:0] exp);
    int n;
    n = cof_partner_inst.got.size();
    cof_partner_inst.send(v);
    repeat (12) @(negedge clk);
    `CHK("dac_code", exp, cof_partner_inst.got[n])
  endtask : xfer

  task automatic wr_mask(input logic [7:0] v);
    @(negedge clk);
    mask_write = 1'b1;
    mask_wdata = v;
    @(negedge clk);
    mask_write = 1'b0;
    @(negedge clk);
  endtask : wr_mask

  task automatic t_map();
    logic [63:0] tbl [3] = '{64'h0090_0010_2000_0100,
      64'h1234_0000_4000_1234, 64'h0010_FFF0_4000_0020};
    `CHK("mask_reset", 8'hFF, mask_q)
    foreach (tbl[i]) begin
      offset = tbl[i][47:32];
      gain = tbl[i][31:16];
      xfer(tbl[i][15:0], tbl[i][63:48]);
    end
    $display("test map done");
  endtask : t_map

  task automatic t_clamp();
    limits = 64'h0040_0FF0_0100_0F00;
    offset = 16'h0000;
    xfer(16'h00FF, 16'h0040);
    xfer(16'h0100, 16'h0100);
    xfer(16'h0F00, 16'h0F00);
    xfer(16'h0F01, 16'h0FF0);
    coef = '{16'h4000, 16'h0000, 16'h0000, 16'h4000, 16'h0000, 16'h0000};
    xfer(16'h0F01, 16'h0FF0);
    limits = 64'h0000_FFFF_0000_FFFF;
    $display("test clamp done");
  endtask : t_clamp

  task automatic t_filter();
    int n;
    n = cof_partner_inst.got.size();
    repeat (3) cof_partner_inst.send(16'h0000);
    repeat (16) @(negedge clk);
    `CHK("flushed", 16'h0000, cof_partner_inst.got[n + 2])
    coef = '{16'h4000, 16'h2000, 16'h0000,
      16'h4000, 16'h4000, 16'h0000};
    xfer(16'h0800, 16'h0800);
    xfer(16'h0000, 16'h0C00);
    xfer(16'h0000, 16'h0600);
    coef = '{16'h4000, 16'h0000, 16'h4000, 16'h0000, 16'h0000, 16'h4000};
    xfer(16'h0100, 16'h0400);
    coef.a0 = 16'h0000;
    xfer(16'h0321, 16'h0321);
    $display("test filter done");
  endtask : t_filter

  task automatic t_config();
    logic [6:0] pat [2] = '{7'h55, 7'h2A};
    foreach (pat[i]) begin
      fcfg = pat[i];
      repeat (2) @(negedge clk);
      `CHK("frontend", pat[i], {pd_q, thr_q, p_off, t_off})
    end
    $display("test config done");
  endtask : t_config

  task automatic t_fault();
    logic [27:0] tbl [8] = '{28'h0100100, 28'h0100200, 28'h0200040,
      28'h0400010, 28'h1000008, 28'h2000004, 28'h4000002, 28'h8000001};
    foreach (tbl[i]) begin
      mon = tbl[i][19:0];
      repeat (6) @(negedge clk);
      `CHK("chain_status", tbl[i][27:20], chain_st)
      mon = '0;
      repeat (6) @(negedge clk);
    end
    for (int r = 0; r < 10; r++) begin
      mon = 20'h00400 << r;
      repeat (6) @(negedge clk);
      `CHK("supply_status", 1'b1, sup_st)
      mon = '0;
      repeat (6) @(negedge clk);
    end
    wr_mask(8'hEF);
    `CHK("mask", 8'hEF, mask_q)
    mon.pressure_amp_over_limit = 1'b1;
    repeat (40) @(negedge clk);
    `CHK("masked_status", 8'h00, chain_st)
    `CHK("masked_force", 1'b0, dac_code === 16'hBEEF)
    mon = '0;
    wr_mask(8'hFF);
    mon.pressure_amp_over_limit = 1'b1;
    repeat (12) @(negedge clk);
    `CHK("early_force", 1'b0, dac_code === 16'hBEEF)
    repeat (20) @(negedge clk);
    `CHK("fault_code", 16'hBEEF, dac_code)
    mon = '0;
    diag_on = 1'b0;
    repeat (6) @(negedge clk);
    mon.rail_under[4] = 1'b1;
    repeat (40) @(negedge clk);
    `CHK("diag_off_force", 1'b0, dac_code === 16'hBEEF)
    diag_on = 1'b1;
    repeat (40) @(negedge clk);
    `CHK("supply_force", 16'hBEEF, dac_code)
    mon = '0;
    repeat (6) @(negedge clk);
    $display("test fault done");
  endtask : t_fault

  task automatic t_nvm();
    nvm_crc_good = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("crc_zero", 16'h0000, dac_code)
    nvm_crc_good = 1'b1;
    xfer(16'h0200, 16'h0200);
    nvm_corrupt = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("corrupt_zero", 16'h0000, dac_code)
    diag_on = 1'b0;
    xfer(16'h0300, 16'h0300);
    nvm_corrupt = 1'b0;
    diag_on = 1'b1;
    $display("test nvm done");
  endtask : t_nvm

  task automatic t_hard();
    for (int k = 0; k < 2; k++) begin
      exec_err = (k == 0);
      sum_err = (k == 1);
      repeat (8) @(negedge clk);
      `CHK("dac_enable", 1'b0, dac_enable)
      `CHK("hard_code", 16'h0000, dac_code)
      `CHK("ready", 1'b0, sample_ready)
      exec_err = 1'b0;
      sum_err = 1'b0;
      repeat (8) @(negedge clk);
      xfer(16'h0123, 16'h0123);
      `CHK("dac_enable_on", 1'b1, dac_enable)
    end
    $display("test hard done");
  endtask : t_hard

  // Reset, then every scenario in turn
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    t_map();
    t_clamp();
    t_filter();
    t_config();
    t_fault();
    t_nvm();
    t_hard();
    report_and_stop();
  end
endmodule : test_compensation_output_clamp_filter_diag
`default_nettype wire
